// ---- verilog/dpi_consts.vh ----
// Constants for the DRAM power-up and initialization sequencer.
`ifndef DPI_CONSTS_VH
`define DPI_CONSTS_VH
`define DPI_CLK_NS            50
`define DPI_AUTO_INIT_MAX_NS  10000
`define DPI_AUTO_INIT_CYC     ((`DPI_AUTO_INIT_MAX_NS) / (`DPI_CLK_NS))
`define DPI_CAL_WAIT_NS       1000
`define DPI_CAL_WAIT_CYC      (((`DPI_CAL_WAIT_NS) + (`DPI_CLK_NS) - 1) / (`DPI_CLK_NS))
`define DPI_AUTO_INIT_LAT     16
`define DPI_CMD_W             4
`define DPI_CMD_NOP           4'h0
`define DPI_CMD_MRW           4'h1
`define DPI_CMD_MRR           4'h2
`define DPI_CMD_PD_ENTRY      4'h3
`define DPI_CMD_PD_EXIT       4'h4
`define DPI_CMD_PREA          4'h5
`define DPI_MA_MR0            8'h00
`define DPI_MA_MR1            8'h01
`define DPI_MA_MR2            8'h02
`define DPI_MA_MR3            8'h03
`define DPI_MA_MR10           8'h0a
`define DPI_MA_RESET          8'h3f
`define DPI_MR0_DAI_BIT       0
`endif

// ---- verilog/dpi_init_seq.v ----
// Device-side power-up and initialization state tracker for a low-power DDR2 memory.
// Notes on behaviour
// - Outputs high impedance while CKE sampled low.
// - Only reads, power-down, NOPs and reset until auto-init done.
// - Auto-init bit reports progress, clears when done.
// - Auto-init completes within 10us of reset.
// - Ready 1us after calibration command.
// - Reset command restarts sequence at reset step.
// - CKE and chip select sampled rising edge.
// - Each command occupies one clock cycle.
`timescale 1ns/1ps
`include "dpi_consts.vh"
module dpi_init_seq #(
   parameter AUTO_INIT_CYC = `DPI_AUTO_INIT_CYC,
   parameter CAL_WAIT_CYC  = `DPI_CAL_WAIT_CYC,
   // The latency is clipped to AUTO_INIT_CYC, so a larger value only models a slow part.
   parameter AUTO_INIT_LAT = `DPI_AUTO_INIT_LAT
)
(
   input  wire                  ref_clk,
   input  wire                  rst,
   input  wire                  clk_en,
   input  wire                  cke,
   input  wire                  cs_n,
   input  wire [`DPI_CMD_W-1:0] cmd,
   input  wire [7:0]            mr_addr,
   input  wire [7:0]            mr_data,
   output reg  [7:0]            rd_data_ff,
   output reg                   rd_data_oe_ff,
   output reg                   rd_valid_ff,
   output reg                   dai_busy_ff,
   output reg                   cmd_illegal_ff,
   output reg                   cal_busy_ff,
   output reg                   ready_ff,
   output reg  [2:0]            cfg_done_ff
);
   // POWER waits for the first reset command, AINIT runs the internal auto-init,
   // IDLE waits for calibration, CAL counts the calibration wait and RUN accepts
   // the configuration writes.
   localparam ST_POWER = 5'h01;
   localparam ST_AINIT = 5'h02;
   localparam ST_IDLE  = 5'h04;
   localparam ST_CAL   = 5'h08;
   localparam ST_RUN   = 5'h10;

   reg  [4:0]  state_ff;
   reg  [4:0]  nxt_state;
   reg  [15:0] cnt_ff;
   reg  [15:0] nxt_cnt;
   reg  [7:0]  mr1_ff;
   reg  [7:0]  mr2_ff;
   reg  [7:0]  mr3_ff;
   reg  [7:0]  mr0_rd;

   // A command exists only with CKE high and chip select low at the rising edge.
   wire sel = cke & ~cs_n;
   wire is_reset = sel && cmd == `DPI_CMD_MRW && mr_addr == `DPI_MA_RESET;
   wire is_mrr = sel && cmd == `DPI_CMD_MRR;
   wire is_mrw = sel && cmd == `DPI_CMD_MRW;
   wire is_pd = sel && (cmd == `DPI_CMD_PD_ENTRY || cmd == `DPI_CMD_PD_EXIT);
   wire quiet = ~sel || cmd == `DPI_CMD_NOP;

   // During auto-init only mode reads, power-down moves, NOPs and reset are legal; anything else
   // is flagged and otherwise ignored, so a careless controller cannot derail the
   // sequence.
   wire ainit_bad = state_ff == ST_AINIT && !is_reset && !quiet && !is_mrr && !is_pd;

   // Mode register 0 carries only the auto-init busy flag; every other bit reads zero.
   always @*
   begin
      mr0_rd = 8'h00;
      mr0_rd[`DPI_MR0_DAI_BIT] = state_ff == ST_AINIT;
   end

   // True on the last cycle of a timed state.
   function cnt_done;
      input [15:0] cnt;
      begin
         cnt_done = cnt <= 16'h0001;
      end
   endfunction

   // Decodes a mode register write to one address.
   function mrw_hit;
      input       wr;
      input [7:0] addr;
      input [7:0] target;
      begin
         mrw_hit = wr && addr == target;
      end
   endfunction

   // Auto-init completes at the earlier of the internal latency and the limit.
   function [15:0] ainit_len;
      input integer lat;
      input integer lim;
      begin
         ainit_len = (lat < lim) ? lat[15:0] : lim[15:0];
      end
   endfunction

   // A reset command wins in every state, so a restart in the run state drops
   // ready at once and the controller must run the whole sequence again.
   always @*
   begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      if (is_reset)
      begin
         nxt_state = ST_AINIT;
         nxt_cnt = ainit_len(AUTO_INIT_LAT, AUTO_INIT_CYC);
      end
      else
      begin
         case (state_ff)
            // Only a reset command leaves the power state, which covers the idle before it.
            ST_POWER: nxt_cnt = 16'h0000;
            ST_AINIT:
            begin
               if (cnt_done(cnt_ff))
                  nxt_state = ST_IDLE;
               else
                  nxt_cnt = cnt_ff - 16'h0001;
            end
            // A calibration request before auto-init has finished is dropped, and flagged as illegal while auto-init runs.
            ST_IDLE:
            begin
               if (mrw_hit(is_mrw, mr_addr, `DPI_MA_MR10))
               begin
                  nxt_state = ST_CAL;
                  nxt_cnt = CAL_WAIT_CYC[15:0];
               end
            end
            ST_CAL:
            begin
               if (cnt_done(cnt_ff))
                  nxt_state = ST_RUN;
               else
                  nxt_cnt = cnt_ff - 16'h0001;
            end
            // Ready holds until the next reset command; nothing else leaves this state.
            ST_RUN: nxt_cnt = 16'h0000;
            default:
            begin
               nxt_state = ST_POWER;
               nxt_cnt = 16'h0000;
            end
         endcase
      end
   end

   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_ff       <= ST_POWER;
         cnt_ff         <= 16'h0000;
         mr1_ff         <= 8'h00;
         mr2_ff         <= 8'h00;
         mr3_ff         <= 8'h00;
         rd_data_ff     <= 8'h00;
         rd_data_oe_ff  <= 1'b0;
         rd_valid_ff    <= 1'b0;
         dai_busy_ff    <= 1'b0;
         cmd_illegal_ff <= 1'b0;
         cal_busy_ff    <= 1'b0;
         ready_ff       <= 1'b0;
         cfg_done_ff    <= 3'b000;
      end
      // A low clock enable freezes every register, so all waits stretch with it.
      else if (clk_en)
      begin
         state_ff    <= nxt_state;
         cnt_ff      <= nxt_cnt;
         dai_busy_ff <= nxt_state == ST_AINIT;
         cal_busy_ff <= nxt_state == ST_CAL;
         ready_ff    <= nxt_state == ST_RUN;
         cmd_illegal_ff <= ainit_bad;
         // Written values survive a reset command; only the written flags clear,
         // so the controller must rewrite all three registers after every restart.
         if (is_reset)
            cfg_done_ff <= 3'b000;
         else if (state_ff == ST_RUN)
         begin
            if (mrw_hit(is_mrw, mr_addr, `DPI_MA_MR1))
            begin
               mr1_ff <= mr_data;
               cfg_done_ff[0] <= 1'b1;
            end
            if (mrw_hit(is_mrw, mr_addr, `DPI_MA_MR2))
            begin
               mr2_ff <= mr_data;
               cfg_done_ff[1] <= 1'b1;
            end
            if (mrw_hit(is_mrw, mr_addr, `DPI_MA_MR3))
            begin
               mr3_ff <= mr_data;
               cfg_done_ff[2] <= 1'b1;
            end
         end
         rd_valid_ff <= is_mrr;
         // Drivers stay off whenever CKE is low, so a read cannot collide at power-up.
         // Read data keeps its last value while the driver is off; only the enable
         // decides whether anything leaves the pins.
         rd_data_oe_ff <= is_mrr & cke;
         if (is_mrr)
         begin
            case (mr_addr)
               `DPI_MA_MR0: rd_data_ff <= mr0_rd;
               `DPI_MA_MR1: rd_data_ff <= mr1_ff;
               `DPI_MA_MR2: rd_data_ff <= mr2_ff;
               `DPI_MA_MR3: rd_data_ff <= mr3_ff;
               default:     rd_data_ff <= 8'h00;
            endcase
         end
      end
   end
endmodule

// ---- tb/dpi_ctrl_model.sv ----
// Controller model that drives clock enable and commands.
`timescale 1ns/1ps
module dpi_ctrl_model (
   input  wire       ref_clk,
   output reg        cke,
   output reg        cs_n,
   output reg  [3:0] cmd,
   output reg  [7:0] mr_addr,
   output reg  [7:0] mr_data
);
   // Each minimum wait is rounded up to whole periods of the boot clock.
   localparam integer CLK_NS            = 50;
   localparam integer CKE_LOW_WAIT      = (100 + CLK_NS - 1) / CLK_NS;
   localparam integer CLOCK_STABLE_WAIT = 5;
   localparam integer NOP_IDLE_WAIT     = (200000 + CLK_NS - 1) / CLK_NS;
   localparam integer POST_RESET_WAIT   = (1000 + CLK_NS - 1) / CLK_NS;
   reg               sw_ready;
   initial
   begin
      cke = 1'h0;
      cs_n = 1'h0;
      cmd = 4'h0;
      mr_addr = 8'h00;
      mr_data = 8'h00;
      sw_ready = 1'h0;
   end
   // Address is inverted after use so a stale value never passes for a new one.
   task issue(input [3:0] c, input [7:0] a, input [7:0] d);
   begin
      @(posedge ref_clk);
      #1 cmd = c;
      mr_addr = a;
      mr_data = d;
      // A reset command takes the configuration away again.
      if (c == 4'h1 && a == 8'h3f)
         sw_ready = 1'h0;
      @(posedge ref_clk);
      #1 cmd = 4'h0;
      mr_addr = ~a;
   end
   endtask
   task power_up;
   begin
      // Waiting for both minimums in turn keeps each of them with room to spare.
      repeat (CKE_LOW_WAIT + CLOCK_STABLE_WAIT) @(posedge ref_clk);
      #1 cke = 1'h1;
      repeat (NOP_IDLE_WAIT) @(posedge ref_clk);
   end
   endtask
   // Software sees the flag only after all three configuration writes.
   task configure(input [7:0] d1, input [7:0] d2, input [7:0] d3);
   begin
      issue(4'h1, 8'h01, d1);
      issue(4'h1, 8'h02, d2);
      issue(4'h1, 8'h03, d3);
      sw_ready = 1'h1;
   end
   endtask
endmodule

// ---- tb/dpi_init_seq_assertions.sv ----
// Checker on the sequencer ports.
`timescale 1ns/1ps
module dpi_init_seq_assertions #(
   parameter int AUTO_INIT_LAT = 16,
   parameter int AUTO_INIT_CYC = 200,
   parameter int CAL_WAIT_CYC  = 20
)
(
   input wire       ref_clk,
   input wire       rst,
   input wire       clk_en,
   input wire       cke,
   input wire       cs_n,
   input wire [3:0] cmd,
   input wire [7:0] mr_addr,
   input wire [7:0] rd_data_ff,
   input wire       rd_data_oe_ff,
   input wire       rd_valid_ff,
   input wire       dai_busy_ff,
   input wire       cmd_illegal_ff,
   input wire       cal_busy_ff,
   input wire       ready_ff
);
   // The busy flag is seen high for the clipped latency, counted from its first high sample.
   localparam int DL = (AUTO_INIT_LAT < AUTO_INIT_CYC) ? AUTO_INIT_LAT : AUTO_INIT_CYC;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire tk = clk_en && cke && !cs_n;
   property p_hiz; !cke |=> !rd_data_oe_ff; endproperty
   a_hiz: assert property (p_hiz) else $error("data driven while disabled");
   property p_mrr; tk && cmd == 4'h2 |=> rd_valid_ff && rd_data_oe_ff; endproperty
   a_mrr: assert property (p_mrr) else $error("read not answered");
   property p_rst; tk && cmd == 4'h1 && mr_addr == 8'h3f |=> dai_busy_ff && !ready_ff; endproperty
   a_rst: assert property (p_rst) else $error("restart not taken");
   property p_dai; $rose(dai_busy_ff) |-> ##[DL:DL] !dai_busy_ff; endproperty
   a_dai: assert property (p_dai) else $error("auto init length wrong");
   property p_poll; rd_valid_ff && dai_busy_ff && $past(mr_addr) == 8'h00 |-> rd_data_ff[0]; endproperty
   a_poll: assert property (p_poll) else $error("busy bit not reported");
   property p_ill; tk && cmd == 4'h1 && mr_addr != 8'h3f && dai_busy_ff |=> cmd_illegal_ff; endproperty
   a_ill: assert property (p_ill) else $error("illegal command not flagged");
   property p_cal; $rose(cal_busy_ff) |-> ##[CAL_WAIT_CYC:CAL_WAIT_CYC] ready_ff && !cal_busy_ff; endproperty
   a_cal: assert property (p_cal) else $error("calibration length wrong");
   property p_rdy; cal_busy_ff |-> !ready_ff; endproperty
   a_rdy: assert property (p_rdy) else $error("ready during calibration");
endmodule
bind dpi_init_seq dpi_init_seq_assertions #(.AUTO_INIT_LAT(AUTO_INIT_LAT), .AUTO_INIT_CYC(AUTO_INIT_CYC),
   .CAL_WAIT_CYC(CAL_WAIT_CYC)) chk_i (.*);

// ---- tb/tb_top.sv ----
// Testbench for the initialization sequencer.
`timescale 1ns/1ps
`include "dpi_consts.vh"
module tb_top;
   reg        ref_clk, rst, clk_en;
   wire       cke, cs_n, rd_data_oe_ff, rd_valid_ff, dai_busy_ff, cmd_illegal_ff, cal_busy_ff, ready_ff;
   wire [3:0] cmd;
   wire [7:0] mr_addr, mr_data, rd_data_ff;
   wire [2:0] cfg_done_ff;
   integer    mismatches, checked, n;
   dpi_ctrl_model dpi_ctrl_model_i (.*);
   // Auto init is lengthened past the post-restart idle so the busy bit can be polled.
   dpi_init_seq #(.AUTO_INIT_LAT(40)) dpi_init_seq_i (.*);
   task chk(input [79:0] nm, input [7:0] exp, input [7:0] got);
   begin
      checked = checked + 1;
      if (got !== exp)
      begin
         mismatches = mismatches + 1;
         $display("unexpected %0s exp %h got %h", nm, exp, got);
      end
   end
   endtask
   task finish_test;
   begin
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask
   task mr(input [3:0] c, input [7:0] a, input [7:0] d);
      dpi_ctrl_model_i.issue(c, a, d);
   endtask
   task t_hiz;
   begin
      mr(`DPI_CMD_MRR, `DPI_MA_MR0, 8'h00);
      chk("oe", 8'h00, 8'(rd_data_oe_ff));
      chk("vld", 8'h00, 8'(rd_valid_ff));
   end
   endtask
   task t_boot;
   begin
      mr(`DPI_CMD_MRW, `DPI_MA_RESET, 8'h00);
      chk("dai", 8'h01, 8'(dai_busy_ff));
      repeat (dpi_ctrl_model_i.POST_RESET_WAIT) @(posedge ref_clk);
      mr(`DPI_CMD_MRW, `DPI_MA_MR1, 8'h00);
      chk("ill", 8'h01, 8'(cmd_illegal_ff));
      n = 0;
      // Read data is taken 1 ns after the edge that samples each read, as soon as the register holds it.
      do
      begin
         mr(`DPI_CMD_MRR, `DPI_MA_MR0, 8'h00);
         n = n + 1;
      end
      while (rd_data_ff[0] === 1'h1 && n < 60);
      chk("polls", 8'h01, 8'(n > 1 && n < 60));
      if (n >= 60)
         finish_test;
      // Only one device hangs on this bus, so no other calibration can overlap.
      mr(`DPI_CMD_MRW, `DPI_MA_MR10, 8'h00);
      chk("cal", 8'h01, 8'(cal_busy_ff));
      n = 0;
      while (ready_ff !== 1'h1 && n < 100)
      begin
         @(posedge ref_clk);
         #1 n = n + 1;
      end
      chk("calcyc", 8'(`DPI_CAL_WAIT_CYC), 8'(n));
      if (n >= 100)
         finish_test;
      dpi_ctrl_model_i.configure(8'ha5, 8'h5a, 8'h3c);
      chk("rdy", 8'(dpi_ctrl_model_i.sw_ready), 8'(ready_ff));
      mr(`DPI_CMD_MRR, `DPI_MA_MR1, 8'h00);
      chk("mr1", 8'ha5, rd_data_ff);
      chk("oe1", 8'h01, 8'(rd_data_oe_ff));
      mr(`DPI_CMD_MRR, `DPI_MA_MR2, 8'h00);
      chk("mr2", 8'h5a, rd_data_ff);
      mr(`DPI_CMD_MRR, `DPI_MA_MR3, 8'h00);
      chk("mr3", 8'h3c, rd_data_ff);
      chk("cfg", 8'h07, 8'(cfg_done_ff));
   end
   endtask
   task t_again;
   begin
      mr(`DPI_CMD_MRW, `DPI_MA_RESET, 8'h00);
      chk("rdy", 8'h00, 8'(ready_ff));
      chk("cfg2", 8'h00, 8'(cfg_done_ff));
      chk("dai2", 8'h01, 8'(dai_busy_ff));
      n = 0;
      while (dai_busy_ff === 1'h1 && n < 250)
      begin
         @(posedge ref_clk);
         #1 n = n + 1;
      end
      chk("ainit2", 8'h01, 8'(n <= `DPI_AUTO_INIT_CYC));
      if (n > `DPI_AUTO_INIT_CYC)
         finish_test;
      mr(`DPI_CMD_MRW, `DPI_MA_MR10, 8'h00);
      chk("cal2", 8'h01, 8'(cal_busy_ff));
   end
   endtask
   initial
   begin
      ref_clk = 1'h0;
      // The period is fixed for the whole run, so the clock never changes mid-sequence.
      forever #25 ref_clk = ~ref_clk;
   end
   initial
   begin
      mismatches = 0;
      checked = 0;
      rst = 1'h1;
      clk_en = 1'h1;
      repeat (6) @(posedge ref_clk);
      #1 rst = 1'h0;
      t_hiz;
      dpi_ctrl_model_i.power_up;
      t_boot;
      t_again;
      finish_test;
   end
endmodule
